// ### tb_uvlo_regs.sv
// Purpose: self-checking bench for the threshold and trim bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   rows are {cmd, data, on code, off code, reject}
`timescale 1ns/100ps
module tb_uvlo_regs;
   logic core_clk, nrst = 0, wr_stb = 0, store_all = 0, nvm_ready;
   logic [7:0] wr_cmd = 8'h00;
   logic [15:0] wr_data = 16'h0000, raw_current = 16'h0100;
   logic [15:0] raw_oc_fault = 16'h0200, raw_oc_warn = 16'h0040;
   logic [15:0] on_thresh_word, off_thresh_word, trim_word, current_readback;
   logic [15:0] oc_fault_limit, oc_warn_limit;
   logic cml_fault, invalid_data, alert_req, nvm_wr;
   logic [47:0] nvm_data, saved;
   logic [43:0] r;
   int miscompares = 0, checks = 0;
   logic [43:0] rows [15] = '{44'h35_F014_14_10_0, 44'h35_F040_14_10_1,
      44'h35_F010_14_10_1, 44'h36_F014_14_10_1, 44'h36_F013_14_13_0,
      44'h35_F013_14_13_1, 44'h36_F01F_14_13_1, 44'h36_F00F_14_13_1,
      44'h35_F01F_1F_13_0, 44'h36_F01E_1F_1E_0, 44'h36_F015_1F_15_0,
      44'h20_F000_1F_15_0, 44'h35_E82D_17_15_0, 44'h36_E82B_17_16_0,
      44'h36_E82F_17_16_1};
   uvlo_regs dut (.core_clk, .nrst, .wr_stb, .wr_cmd, .wr_data, .store_all,
      .nvm_ready, .raw_current, .raw_oc_fault, .raw_oc_warn, .on_thresh_word,
      .off_thresh_word, .trim_word, .current_readback, .oc_fault_limit,
      .oc_warn_limit, .cml_fault, .invalid_data, .alert_req, .nvm_wr,
      .nvm_data);
   uvlo_nvm_model nvm (.core_clk, .nvm_wr, .nvm_data, .nvm_ready, .saved);
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge core_clk) #1;
      wr_stb = 1;
      wr_cmd = c;
      wr_data = d;
      @(posedge core_clk) #1;
      wr_stb = 0;
   endtask
   task automatic do_reset;
      nrst = 0;
      repeat (5) @(posedge core_clk);
      #1 nrst = 1;
      chk({on_thresh_word, off_thresh_word, trim_word}, 48'hF012_F010_E000);
      $display("reset test done");
   endtask
   task automatic conclude;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      #5000 miscompares++;
      conclude();
   end
   initial begin
      do_reset();
      for (int i = 0; i < 15; i++) begin
         r = rows[i];
         wr(r[43:36], r[35:20]);
         chk(48'(on_thresh_word), 48'({5'h1E, 4'h0, r[18:12]}));
         chk(48'(off_thresh_word), 48'({5'h1E, 4'h0, r[10:4]}));
         chk(48'({cml_fault, invalid_data, alert_req}), {48{r[0]}} & 48'h7);
      end
      $display("row test done");
      wr(8'h39, 16'h07FF);
      chk(48'(trim_word), 48'hE7FF);
      @(posedge core_clk) #1;
      chk({current_readback, oc_fault_limit, oc_warn_limit},
         48'h00FF_01FF_003F);
      wr(8'h39, 16'h0045);
      chk(48'({trim_word, cml_fault}), 48'h1_C00A);
      @(posedge core_clk) #1;
      store_all = 1;
      @(posedge core_clk) #1;
      store_all = 0;
      repeat (2) @(posedge core_clk);
      chk(saved, 48'hF017_F016_E005);
      $display("trim and store test done");
      do_reset();
      conclude();
   end
endmodule

// ### uvlo_nvm_model.sv
// Purpose: nonvolatile store stand-in
// Assumes: nvm_wr is a one-cycle pulse with all three words
// Notes:   goes busy after each write, so it answers slowly too
`timescale 1ns/100ps
module uvlo_nvm_model (
   input  wire logic        core_clk,
   input  wire logic        nvm_wr,
   input  wire logic [47:0] nvm_data,
   output logic             nvm_ready,
   output logic [47:0]      saved
);
   int busy = 0;
   assign nvm_ready = (busy == 0);
   always @(posedge core_clk) begin
      if (nvm_wr)
         saved <= nvm_data;
      busy <= nvm_wr ? 3 : (busy > 0 ? busy - 1 : 0);
   end
endmodule

// ### uvlo_pkg.sv
// Purpose: constants for the input threshold and current trim register bank
// Assumes: word-wide command writes already decoded from the management bus
// Notes:   linear format, 5-bit exponent over 11-bit mantissa
package uvlo_pkg;
   localparam logic [7:0]  CMD_ON_THRESH   = 8'h35;
   localparam logic [7:0]  CMD_OFF_THRESH  = 8'h36;
   localparam logic [7:0]  CMD_CUR_TRIM    = 8'h39;
   localparam int          EXP_LSB         = 11;
   localparam logic [4:0]  THRESH_EXP      = 5'h1E;
   localparam logic [4:0]  TRIM_EXP        = 5'h1C;
   localparam logic [10:0] ON_MIN          = 11'h011;
   localparam logic [10:0] ON_MAX          = 11'h01F;
   localparam logic [10:0] ON_RESET        = 11'h012;
   localparam logic [10:0] OFF_MIN         = 11'h010;
   localparam logic [10:0] OFF_MAX         = 11'h01E;
   localparam logic [10:0] OFF_RESET       = 11'h010;
   localparam logic [6:0]  TRIM_RESET      = 7'h00;
   localparam int          TRIM_LOW_BITS   = 6;
   localparam int          TRIM_SIGN_BIT   = 10;
endpackage

// ### uvlo_regs.sv
// Purpose: input turn-on/turn-off thresholds and output current offset trim
// Assumes: host interface presents one-cycle write strobe with full word
// Notes:   rejected writes pulse invalid-data; status flags live elsewhere
//
// Functional notes
// - turn-on register holds start input voltage
// - in-range values round to nearest step
// - out-of-range turn-on write rejected, flagged, alert
// - turn-on codes 17 to 31 accepted
// - turn-on resets to code 18
// - threshold exponents fixed at minus two
// - turn-on must stay above turn-off
// - exponent over mantissa, only low bits writable
// - turn-off register holds stop input voltage
// - out-of-range turn-off write rejected, flagged, alert
// - turn-off codes 16 to 30, reset 16
// - turn-off writable width resolved to five bits
// - store-all copies registers to nonvolatile memory
// - trim applied to current readback and limits
// - trim 62.5 mA steps, -4 to +3.9375
// - trim aliases, exponent fixed, upper bits sign
`timescale 1ns/100ps
module uvlo_regs (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        wr_stb,
   input  wire logic [7:0]  wr_cmd,
   input  wire logic [15:0] wr_data,
   input  wire logic        store_all,
   input  wire logic        nvm_ready,
   input  wire logic [15:0] raw_current,
   input  wire logic [15:0] raw_oc_fault,
   input  wire logic [15:0] raw_oc_warn,
   output logic [15:0]      on_thresh_word,
   output logic [15:0]      off_thresh_word,
   output logic [15:0]      trim_word,
   output logic [15:0]      current_readback,
   output logic [15:0]      oc_fault_limit,
   output logic [15:0]      oc_warn_limit,
   output logic             cml_fault,
   output logic             invalid_data,
   output logic             alert_req,
   output logic             nvm_wr,
   output logic [47:0]      nvm_data
);
   typedef struct packed {
      logic [10:0] on_mant;
      logic [10:0] off_mant;
      logic [6:0]  trim;      // sign plus six low bits
      logic        bad;
      logic        nvm_wr;
      logic [47:0] nvm_data;
      logic [15:0] cur;
      logic [15:0] ocf;
      logic [15:0] ocw;
   } uvlo_state_t;

   uvlo_state_t st_reg;
   uvlo_state_t st_next;

   // quarter-volt code from a linear word, rounded to nearest step
   function automatic logic [15:0] uvlo_to_code(input logic [15:0] w);
      logic signed [4:0]  e;
      logic [10:0]        m;
      logic [31:0]        v;
      e = w[15:11];
      m = w[10:0];
      v = 32'h0;
      if (e >= -5'sd2) begin
         v = {21'h0, m} << (e + 5'sd2);
      end else begin
         // add half the dropped weight before the shift
         v = ({21'h0, m} + (32'h1 << (-e - 5'sd3))) >> (-e - 5'sd2);
      end
      uvlo_to_code = (v > 32'h0000FFFF) ? 16'hFFFF : v[15:0];
   endfunction

   // trim in 1/16 A units, sign extended from the 7-bit stored trim
   function automatic logic [15:0] uvlo_trim_ext(input logic [6:0] t);
      uvlo_trim_ext = {{10{t[6]}}, t[5:0]};
   endfunction

   always_comb begin
      logic [15:0] code;
      logic        on_ok;
      logic        off_ok;
      logic [15:0] ext;
      code = uvlo_to_code(wr_data);
      on_ok = 1'b0;
      off_ok = 1'b0;
      ext = uvlo_trim_ext(st_reg.trim);
      st_next = st_reg;
      st_next.bad = 1'b0;
      st_next.nvm_wr = 1'b0;
      if (wr_stb && wr_cmd == uvlo_pkg::CMD_ON_THRESH) begin
         on_ok = (code >= {5'h0, uvlo_pkg::ON_MIN})
              && (code <= {5'h0, uvlo_pkg::ON_MAX});
         // compared with the stored turn-off after rounding
         on_ok = on_ok && (code > {5'h0, st_reg.off_mant});
         if (on_ok) begin
            st_next.on_mant = code[10:0];
         end else begin
            st_next.bad = 1'b1;
         end
      end
      if (wr_stb && wr_cmd == uvlo_pkg::CMD_OFF_THRESH) begin
         off_ok = (code >= {5'h0, uvlo_pkg::OFF_MIN})
               && (code <= {5'h0, uvlo_pkg::OFF_MAX});
         off_ok = off_ok && (code < {5'h0, st_reg.on_mant});
         if (off_ok) begin
            // range 16..30 needs five writable bits, not four or seven
            st_next.off_mant = code[10:0];
         end else begin
            st_next.bad = 1'b1;
         end
      end
      if (wr_stb && wr_cmd == uvlo_pkg::CMD_CUR_TRIM) begin
         // exponent ignored; bits 9:6 dropped so values alias
         st_next.trim = {wr_data[uvlo_pkg::TRIM_SIGN_BIT],
                         wr_data[uvlo_pkg::TRIM_LOW_BITS-1:0]};
      end
      if (store_all && nvm_ready) begin
         st_next.nvm_wr = 1'b1;
         st_next.nvm_data = {on_thresh_word, off_thresh_word, trim_word};
      end
      // offset in 62.5 mA counts added to current and both limits
      st_next.cur = raw_current + ext;
      st_next.ocf = raw_oc_fault + ext;
      st_next.ocw = raw_oc_warn + ext;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
         st_reg.on_mant <= uvlo_pkg::ON_RESET;
         st_reg.off_mant <= uvlo_pkg::OFF_RESET;
         st_reg.trim <= uvlo_pkg::TRIM_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // fixed exponents in front of the stored mantissas
   assign on_thresh_word  = {uvlo_pkg::THRESH_EXP, st_reg.on_mant};
   assign off_thresh_word = {uvlo_pkg::THRESH_EXP, st_reg.off_mant};
   assign trim_word       = {uvlo_pkg::TRIM_EXP,
                             {4{st_reg.trim[6]}}, st_reg.trim};
   assign current_readback = st_reg.cur;
   assign oc_fault_limit   = st_reg.ocf;
   assign oc_warn_limit    = st_reg.ocw;
   assign cml_fault    = st_reg.bad;
   assign invalid_data = st_reg.bad;
   assign alert_req    = st_reg.bad;
   assign nvm_wr       = st_reg.nvm_wr;
   assign nvm_data     = st_reg.nvm_data;
endmodule

// ### uvlo_regs_monitor.sv
// Purpose: port checks for the threshold and trim bank
// Assumes: one clock, async active-low reset
// Notes:   reject pulses are seen one cycle after the taking edge
`timescale 1ns/100ps
module uvlo_regs_monitor (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        wr_stb,
   input wire logic [7:0]  wr_cmd,
   input wire logic [15:0] wr_data,
   input wire logic [15:0] raw_current,
   input wire logic [15:0] on_thresh_word,
   input wire logic [15:0] off_thresh_word,
   input wire logic [15:0] trim_word,
   input wire logic [15:0] current_readback,
   input wire logic        cml_fault,
   input wire logic        invalid_data,
   input wire logic        alert_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_bad_on;
      wr_stb && wr_cmd == uvlo_pkg::CMD_ON_THRESH && wr_data[10:0] > 11'h03F
      && wr_data[15:11] == uvlo_pkg::THRESH_EXP;
   endsequence
   AST_BAD_ON: assert property (s_bad_on |=>
      cml_fault && $stable(on_thresh_word)) else $error("bad write kept");
   AST_KEEP: assert property (cml_fault |-> $stable(off_thresh_word)
      && $stable(on_thresh_word)) else $error("rejected value stored");
   AST_FLAGS: assert property (cml_fault == invalid_data
      && alert_req == cml_fault) else $error("flags disagree");
   AST_EXP: assert property (on_thresh_word[15:11] == 5'h1E
      && off_thresh_word[15:11] == 5'h1E) else $error("exponent moved");
   AST_ORDER: assert property (
      on_thresh_word[10:0] > off_thresh_word[10:0]) else $error("order lost");
   AST_RANGE: assert property (on_thresh_word[10:0] >= 11'h011
      && on_thresh_word[10:0] <= 11'h01F && off_thresh_word[10:0] <= 11'h01E
      && off_thresh_word[10:0] >= 11'h010) else $error("range left");
   AST_TRIM: assert property (trim_word[15:11] == 5'h1C
      && trim_word[10:6] == {5{trim_word[10]}}) else $error("trim form");
   AST_CUR: assert property ($past(nrst) |-> current_readback ==
      16'($past(raw_current) + {{5{$past(trim_word[10])}},
      $past(trim_word[10:0])})) else $error("readback offset wrong");
endmodule
bind uvlo_regs uvlo_regs_monitor mon (.core_clk, .nrst, .wr_stb, .wr_cmd,
   .wr_data, .raw_current, .on_thresh_word, .off_thresh_word, .trim_word,
   .current_readback, .cml_fault, .invalid_data, .alert_req);
